/* common/dcc_pkg.sv */
// Constants, register layout and carrier types of the DMA channel control block
package dcc_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_EXT = 2;
  localparam int NUM_PERIPH = 6;
  localparam int CNT_W = 24;
  localparam int CTRL_W = 21;
  // Register map, byte addresses
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_COUNT0 = 8'h10;
  localparam logic [7:0] OFF_PTR3 = 8'h20;
  localparam logic [7:0] OFF_OPER = 8'h24;
  localparam logic [7:0] REG_STRIDE = 8'h04;
  // Bit positions
  localparam int BIT_TE = 1;
  localparam int BIT_DME = 0;
  localparam int BIT_NMI_FLAG = 1;
  localparam int BIT_AE = 2;
  // Request source codes
  localparam logic [3:0] RS_EXT_DUAL = 4'h0;
  localparam logic [3:0] RS_EXT_MEM2DEV = 4'h2;
  localparam logic [3:0] RS_EXT_DEV2MEM = 4'h3;
  localparam logic [3:0] RS_AUTO = 4'h4;
  localparam logic [3:0] RS_PERIPH_LO = 4'ha;
  // Unit sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_16B = 2'h3;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  // Address step codes
  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [31:0] PTR_STEP = 32'h0000_0004;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

  typedef struct packed {
    logic indirect_select;
    logic [3:0] rsvd_hi;
    logic [1:0] dst_step;
    logic [1:0] src_step;
    logic [3:0] req_source;
    logic rsvd7;
    logic req_detect_select;
    logic bus_mode_select;
    logic [1:0] unit_size;
    logic done_irq_enable;
    logic transfer_end_flag;
    logic channel_enable;
  } dcc_ctrl_t;

  typedef struct packed {
    logic [1:0] chan;
    logic ptr_fetch;
    logic [1:0] size;
    logic last_beat;
    logic single;
    logic burst;
  } dcc_xfer_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PTR = 3'b010,
    ST_DATA = 3'b100
  } dcc_state_t;
endpackage : dcc_pkg

/* verilog/dcc_req_detect.sv */
// External request pin synchroniser with level and falling-edge outputs
`timescale 1ns/100ps
module dcc_req_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pin side
  input wire logic ext_request_pin_n,
  // Detected request
  output logic req_low,
  output logic req_fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= ext_request_pin_n;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign req_low = ~sync_reg;
  assign req_fall = prev_reg & ~sync_reg;

  a_fall_after_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req_fall |-> req_low && $past(!req_low))
    else $error("falling edge reported without a high-to-low change");
endmodule : dcc_req_detect

/* verilog/dcc_channel_ctrl.sv */
// Four-channel DMA control: registers, request detection, channel sequencing
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dcc_channel_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources
  input wire logic [dcc_pkg::NUM_EXT-1:0] ext_request_pin_n,
  output logic [dcc_pkg::NUM_EXT-1:0] ext_acknowledge_pin_n,
  input wire logic [dcc_pkg::NUM_PERIPH-1:0] periph_req_n,
  // Abort events
  input wire logic nmi_event,
  input wire logic addr_error_event,
  // Transfer port to the bus engine
  output logic xfer_valid,
  output dcc_pkg::dcc_xfer_t xfer,
  output logic [31:0] xfer_src_ptr,
  input wire logic xfer_done,
  // Completion interrupts
  output logic [dcc_pkg::NUM_CH-1:0] done_interrupt
);
  // ==========================================================
  // Declarations
  dcc_pkg::dcc_ctrl_t ctrl_reg [dcc_pkg::NUM_CH];
  logic [dcc_pkg::CNT_W-1:0] count_reg [dcc_pkg::NUM_CH];
  logic [31:0] ctrl_word [dcc_pkg::NUM_CH];
  logic [dcc_pkg::NUM_CH-1:0] te_reg;
  logic [dcc_pkg::NUM_CH-1:0] te_seen_reg;
  logic [dcc_pkg::NUM_CH-1:0] pend_reg;
  logic [dcc_pkg::NUM_CH-1:0] active;
  logic [dcc_pkg::NUM_CH-1:0] trig;
  logic [dcc_pkg::NUM_CH-1:0] edge_evt;
  logic [dcc_pkg::NUM_CH-1:0] take;
  logic [dcc_pkg::NUM_CH-1:0] ext_src;
  logic [dcc_pkg::NUM_CH-1:0] sel_ctrl;
  logic [dcc_pkg::NUM_CH-1:0] sel_count;
  logic [dcc_pkg::NUM_EXT-1:0] ext_low;
  logic [dcc_pkg::NUM_EXT-1:0] ext_fall;
  logic [dcc_pkg::NUM_PERIPH-1:0] periph_prev_reg;
  logic [dcc_pkg::NUM_PERIPH-1:0] periph_fall;
  logic [31:0] ptr3_reg;
  logic master_enable_reg;
  logic nmi_flag_reg;
  logic addr_error_flag_reg;
  logic nmi_seen_reg;
  logic ae_seen_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [31:0] rd_data;
  logic rd_hit;
  logic acc;
  logic fire_wr;
  logic fire_rd;
  logic sel_ptr3;
  logic sel_oper;
  dcc_pkg::dcc_state_t state_reg;
  logic [1:0] cur_reg;
  logic [1:0] beat_reg;
  logic gnt_valid;
  logic [1:0] gnt_ch;
  logic unit_fin;
  logic ptr_fin;
  logic last_unit;
  logic cont;
  logic cur_16b;

  // ==========================================================
  // APB slave, one wait state so read data comes from a flop
  assign acc = psel & penable;
  assign fire_wr = acc & pready_reg & pwrite;
  assign fire_rd = acc & pready_reg & ~pwrite;
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign sel_ptr3 = (paddr == dcc_pkg::OFF_PTR3);
  assign sel_oper = (paddr == dcc_pkg::OFF_OPER);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= acc & ~pready_reg;
      if (acc & ~pready_reg) begin
        prdata_reg <= rd_data;
        pslverr_reg <= ~rd_hit;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int i = 0; i < dcc_pkg::NUM_CH; i++) begin
      if (sel_ctrl[i]) begin
        rd_data = ctrl_word[i];
        rd_hit = 1'b1;
      end
      if (sel_count[i]) begin
        rd_data = {{(32 - dcc_pkg::CNT_W){1'b0}}, count_reg[i]};
        rd_hit = 1'b1;
      end
    end
    if (sel_ptr3) begin
      rd_data = ptr3_reg;
      rd_hit = 1'b1;
    end
    if (sel_oper) begin
      rd_data[dcc_pkg::BIT_DME] = master_enable_reg;
      rd_data[dcc_pkg::BIT_NMI_FLAG] = nmi_flag_reg;
      rd_data[dcc_pkg::BIT_AE] = addr_error_flag_reg;
      rd_hit = 1'b1;
    end
  end

  // ==========================================================
  // Operation register: master enable and abort flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      master_enable_reg <= 1'b0;
    end else if (fire_wr && sel_oper) begin
      master_enable_reg <= pwdata[dcc_pkg::BIT_DME];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_flag_reg <= 1'b0;
      nmi_seen_reg <= 1'b0;
    end else if (nmi_event) begin
      nmi_flag_reg <= 1'b1;
    end else if (fire_wr && sel_oper && nmi_seen_reg && !pwdata[dcc_pkg::BIT_NMI_FLAG]) begin
      nmi_flag_reg <= 1'b0;
      nmi_seen_reg <= 1'b0;
    end else if (fire_rd && sel_oper && prdata_reg[dcc_pkg::BIT_NMI_FLAG]) begin
      nmi_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_error_flag_reg <= 1'b0;
      ae_seen_reg <= 1'b0;
    end else if (addr_error_event) begin
      addr_error_flag_reg <= 1'b1;
    end else if (fire_wr && sel_oper && ae_seen_reg && !pwdata[dcc_pkg::BIT_AE]) begin
      addr_error_flag_reg <= 1'b0;
      ae_seen_reg <= 1'b0;
    end else if (fire_rd && sel_oper && prdata_reg[dcc_pkg::BIT_AE]) begin
      ae_seen_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Request pins and peripheral request edges
  generate
    for (genvar e = 0; e < dcc_pkg::NUM_EXT; e++) begin : g_ext
      dcc_req_detect u_detect (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ext_request_pin_n(ext_request_pin_n[e]),
        .req_low(ext_low[e]),
        .req_fall(ext_fall[e])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      periph_prev_reg <= {dcc_pkg::NUM_PERIPH{1'b1}};
    end else begin
      periph_prev_reg <= periph_req_n;
    end
  end
  assign periph_fall = periph_prev_reg & ~periph_req_n;

  // ==========================================================
  // Per-channel registers and triggers
  generate
    for (genvar i = 0; i < dcc_pkg::NUM_CH; i++) begin : g_ch
      logic [3:0] rs;
      logic [3:0] pidx;
      logic is_ext;
      logic is_periph;
      logic is_auto;
      logic unit_here;

      assign sel_ctrl[i] = (paddr == dcc_pkg::OFF_CTRL0 + 8'(i) * dcc_pkg::REG_STRIDE);
      assign sel_count[i] = (paddr == dcc_pkg::OFF_COUNT0 + 8'(i) * dcc_pkg::REG_STRIDE);
      assign rs = ctrl_reg[i].req_source;
      assign pidx = rs - dcc_pkg::RS_PERIPH_LO;
      assign unit_here = unit_fin && (cur_reg == 2'(i));
      if (i < dcc_pkg::NUM_EXT) begin : g_src
        assign is_ext = (rs == dcc_pkg::RS_EXT_DUAL) || (rs == dcc_pkg::RS_EXT_MEM2DEV) ||
                        (rs == dcc_pkg::RS_EXT_DEV2MEM);
        assign is_periph = (rs >= dcc_pkg::RS_PERIPH_LO);
        assign is_auto = (rs == dcc_pkg::RS_AUTO);
        assign edge_evt[i] = (is_ext && ctrl_reg[i].req_detect_select && ext_fall[i]) ||
                             (is_periph && periph_fall[pidx[2:0]]);
        assign trig[i] = active[i] && (is_auto || pend_reg[i] ||
                         (is_ext && !ctrl_reg[i].req_detect_select && ext_low[i]));
        assign ext_src[i] = is_ext;
      end else begin : g_auto
        assign is_ext = 1'b0;
        assign is_periph = 1'b0;
        assign is_auto = 1'b1;
        assign edge_evt[i] = 1'b0;
        assign trig[i] = active[i];
        assign ext_src[i] = 1'b0;
      end

      assign active[i] = ctrl_reg[i].channel_enable && !te_reg[i] && master_enable_reg &&
                         !nmi_flag_reg && !addr_error_flag_reg;

      always_comb begin
        ctrl_word[i] = {{(32 - dcc_pkg::CTRL_W){1'b0}}, ctrl_reg[i]};
        ctrl_word[i][dcc_pkg::BIT_TE] = te_reg[i];
      end

      // Pending edge request, only while the channel is enabled
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pend_reg[i] <= 1'b0;
        end else if (!active[i]) begin
          pend_reg[i] <= 1'b0;
        end else if (edge_evt[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (take[i]) begin
          pend_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          ctrl_reg[i] <= '0;
        end else if (fire_wr && sel_ctrl[i]) begin
          ctrl_reg[i] <= dcc_pkg::dcc_ctrl_t'(pwdata[dcc_pkg::CTRL_W-1:0]);
          ctrl_reg[i].rsvd_hi <= 4'h0;
          ctrl_reg[i].rsvd7 <= 1'b0;
          ctrl_reg[i].transfer_end_flag <= 1'b0;
          if (i != dcc_pkg::NUM_CH - 1) begin
            ctrl_reg[i].indirect_select <= 1'b0;
          end
          if (i >= dcc_pkg::NUM_EXT) begin
            ctrl_reg[i].req_detect_select <= 1'b0;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          te_reg[i] <= 1'b0;
          te_seen_reg[i] <= 1'b0;
        end else if (unit_here && last_unit) begin
          te_reg[i] <= 1'b1;
        end else if (fire_wr && sel_ctrl[i] && te_seen_reg[i] && !pwdata[dcc_pkg::BIT_TE]) begin
          te_reg[i] <= 1'b0;
          te_seen_reg[i] <= 1'b0;
        end else if (fire_rd && sel_ctrl[i] && prdata_reg[dcc_pkg::BIT_TE]) begin
          te_seen_reg[i] <= 1'b1;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          count_reg[i] <= '0;
        end else if (fire_wr && sel_count[i]) begin
          count_reg[i] <= pwdata[dcc_pkg::CNT_W-1:0];
        end else if (unit_here) begin
          count_reg[i] <= count_reg[i] - dcc_pkg::CNT_ONE;
        end
      end

      assign done_interrupt[i] = te_reg[i] && ctrl_reg[i].done_irq_enable;
    end
  endgenerate

  // ==========================================================
  // Channel 3 indirect source pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr3_reg <= 32'h0000_0000;
    end else if (fire_wr && sel_ptr3) begin
      ptr3_reg <= pwdata;
    end else if (ptr_fin) begin
      unique case (ctrl_reg[3].src_step)
        dcc_pkg::STEP_INC: ptr3_reg <= ptr3_reg + dcc_pkg::PTR_STEP;
        dcc_pkg::STEP_DEC: ptr3_reg <= ptr3_reg - dcc_pkg::PTR_STEP;
        default: ptr3_reg <= ptr3_reg;
      endcase
    end
  end

  // ==========================================================
  // Sequencer: fixed priority, channel 0 first
  always_comb begin
    gnt_valid = 1'b0;
    gnt_ch = 2'h0;
    for (int i = dcc_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (trig[i]) begin
        gnt_valid = 1'b1;
        gnt_ch = 2'(i);
      end
    end
  end

  assign cur_16b = (ctrl_reg[cur_reg].unit_size == dcc_pkg::SZ_16B);
  assign unit_fin = (state_reg == dcc_pkg::ST_DATA) && active[cur_reg] && xfer_done &&
                    (!cur_16b || beat_reg == dcc_pkg::BEAT_LAST);
  assign ptr_fin = (state_reg == dcc_pkg::ST_PTR) && active[cur_reg] && xfer_done;
  assign last_unit = (count_reg[cur_reg] == dcc_pkg::CNT_ONE);
  assign cont = ctrl_reg[cur_reg].bus_mode_select && trig[cur_reg];

  always_comb begin
    take = '0;
    if (state_reg == dcc_pkg::ST_IDLE && gnt_valid) begin
      take[gnt_ch] = 1'b1;
    end else if (unit_fin && !last_unit && cont) begin
      take[cur_reg] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= dcc_pkg::ST_IDLE;
      cur_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        dcc_pkg::ST_IDLE: begin
          if (gnt_valid) begin
            cur_reg <= gnt_ch;
            state_reg <= ctrl_reg[gnt_ch].indirect_select ? dcc_pkg::ST_PTR
                                                          : dcc_pkg::ST_DATA;
          end
        end
        dcc_pkg::ST_PTR: begin
          if (!active[cur_reg]) begin
            state_reg <= dcc_pkg::ST_IDLE;
          end else if (xfer_done) begin
            state_reg <= dcc_pkg::ST_DATA;
          end
        end
        dcc_pkg::ST_DATA: begin
          if (!active[cur_reg]) begin
            state_reg <= dcc_pkg::ST_IDLE;
          end else if (unit_fin) begin
            if (last_unit || !cont) begin
              state_reg <= dcc_pkg::ST_IDLE;
            end else if (ctrl_reg[cur_reg].indirect_select) begin
              state_reg <= dcc_pkg::ST_PTR;
            end
          end
        end
        default: state_reg <= dcc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      beat_reg <= 2'h0;
    end else if (state_reg != dcc_pkg::ST_DATA || !active[cur_reg] || unit_fin) begin
      beat_reg <= 2'h0;
    end else if (xfer_done && cur_16b) begin
      beat_reg <= beat_reg + 2'h1;
    end
  end

  // ==========================================================
  // Transfer port and acknowledge pins
  assign xfer_valid = (state_reg != dcc_pkg::ST_IDLE) && active[cur_reg];
  assign xfer_src_ptr = ptr3_reg;
  always_comb begin
    xfer.chan = cur_reg;
    xfer.ptr_fetch = (state_reg == dcc_pkg::ST_PTR);
    xfer.size = (xfer.ptr_fetch || cur_16b) ? dcc_pkg::SZ_LONG
                                            : ctrl_reg[cur_reg].unit_size;
    xfer.last_beat = !cur_16b || beat_reg == dcc_pkg::BEAT_LAST;
    xfer.single = ext_src[cur_reg] && (ctrl_reg[cur_reg].req_source != dcc_pkg::RS_EXT_DUAL);
    xfer.burst = ctrl_reg[cur_reg].bus_mode_select;
  end

  generate
    for (genvar a = 0; a < dcc_pkg::NUM_EXT; a++) begin : g_ack
      assign ext_acknowledge_pin_n[a] = !(xfer_valid && !xfer.ptr_fetch &&
                                          cur_reg == 2'(a) && ext_src[a]);
    end
  endgenerate

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ptr_fetch_done;
    state_reg == dcc_pkg::ST_PTR && active[cur_reg] && xfer_done;
  endsequence

  a_te_on_last: assert property (unit_fin && last_unit |=> te_reg[$past(cur_reg)])
    else $error("end flag not set after last unit");
  a_abort_no_te: assert property (
    state_reg != dcc_pkg::ST_IDLE && !active[cur_reg] |=> state_reg == dcc_pkg::ST_IDLE &&
    !te_reg[$past(cur_reg)])
    else $error("abort did not stop cleanly");
  a_gate_valid: assert property (xfer_valid |-> ctrl_reg[xfer.chan].channel_enable &&
    !te_reg[xfer.chan] && master_enable_reg && !nmi_flag_reg && !addr_error_flag_reg)
    else $error("transfer offered on a disabled channel");
  a_ptr_step_inc: assert property (
    s_ptr_fetch_done and ctrl_reg[3].src_step == dcc_pkg::STEP_INC && !(fire_wr && sel_ptr3)
    |=> ptr3_reg == $past(ptr3_reg) + dcc_pkg::PTR_STEP)
    else $error("pointer did not step by four");
  a_ptr_then_data: assert property (s_ptr_fetch_done |=> state_reg == dcc_pkg::ST_DATA)
    else $error("pointer fetch not followed by data phase");
  a_indirect_first: assert property (
    state_reg == dcc_pkg::ST_IDLE && gnt_valid && ctrl_reg[gnt_ch].indirect_select
    |=> state_reg == dcc_pkg::ST_PTR)
    else $error("indirect transfer skipped the pointer fetch");
  a_count_hold16: assert property (
    state_reg == dcc_pkg::ST_DATA && xfer_done && cur_16b && beat_reg != dcc_pkg::BEAT_LAST &&
    !(fire_wr && sel_count[cur_reg]) |=> count_reg[$past(cur_reg)] == $past(count_reg[cur_reg]))
    else $error("count moved before four longwords");
  a_ds_hidden: assert property (
    !ctrl_reg[2].req_detect_select && !ctrl_reg[3].req_detect_select)
    else $error("detect select stored on channel 2 or 3");
  a_auto_start: assert property (
    state_reg == dcc_pkg::ST_IDLE && active[3] |=> state_reg != dcc_pkg::ST_IDLE)
    else $error("auto request did not start");
  a_irq_hold: assert property (
    done_interrupt[0] && !(fire_wr && sel_ctrl[0]) |=> done_interrupt[0])
    else $error("done interrupt dropped without a write");
endmodule : dcc_channel_ctrl

/* tb/dcc_partner.sv */
// Bus engine model answering each offered transfer beat after a set delay
`timescale 1ns/100ps
module dcc_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Transfer port
  input wire logic xfer_valid,
  input wire logic [3:0] delay,
  output logic xfer_done
);
  logic [3:0] wait_reg;

  // Done is a one-cycle pulse per beat, only while a beat stands
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !xfer_valid || xfer_done) begin
      wait_reg <= 4'h0;
      xfer_done <= 1'b0;
    end else if (wait_reg == delay) begin
      xfer_done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : dcc_partner

/* tb/tb.sv */
// Register-level testbench for the DMA channel control block
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ext_request_pin_n = 2'h3;
  logic [1:0] ext_acknowledge_pin_n;
  logic nmi_event = 1'b0;
  logic ae_event = 1'b0;
  logic [5:0] periph_n = 6'h3f;
  logic [31:0] src_ptr;
  dcc_pkg::dcc_xfer_t xq;
  logic xfer_valid;
  dcc_pkg::dcc_xfer_t xfer;
  logic xfer_done;
  logic [3:0] done_interrupt;
  logic [3:0] delay = 4'h0;
  logic [31:0] q;
  logic err_q;
  logic ack_seen = 1'b0;
  int beats = 0;
  int b0;
  int num_errors = 0;
  int compares = 0;

  initial forever #25 sys_clk = ~sys_clk;

  dcc_channel_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_request_pin_n(ext_request_pin_n),
    .ext_acknowledge_pin_n(ext_acknowledge_pin_n), .periph_req_n(periph_n),
    .nmi_event(nmi_event), .addr_error_event(ae_event), .xfer_valid(xfer_valid), .xfer(xfer),
    .xfer_src_ptr(src_ptr), .xfer_done(xfer_done), .done_interrupt(done_interrupt));

  dcc_partner partner (.sys_clk(sys_clk), .rst_n(rst_n), .xfer_valid(xfer_valid),
    .delay(delay), .xfer_done(xfer_done));

  always @(posedge sys_clk) begin
    if (xfer_valid && xfer_done) begin
      beats <= beats + 1;
      xq <= xfer;
    end
    if (ext_acknowledge_pin_n[1] === 1'b0)
      ack_seen <= 1'b1;
  end

  task automatic print_verdict;
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang;
    num_errors++;
    $display("[ERR] %0t wait limit reached", $time);
    print_verdict();
  endtask : hang

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 20)
      hang();
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wait_irq(input int ch);
    int n;
    n = 0;
    while (done_interrupt[ch] !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300)
      hang();
  endtask : wait_irq

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'hfc, 32'h0);
    chk(err_q, 1'b1);
    apb(1'b1, 8'h08, 32'h60);
    rd(8'h08, 32'h20);
    apb(1'b1, 8'h00, 32'h60);
    rd(8'h00, 32'h60);
    apb(1'b1, 8'h00, 32'h0);
    $display("Test fields done");
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h00, 32'h405);
    repeat (10) @(posedge sys_clk);
    chk(beats, 0);
    apb(1'b1, 8'h24, 32'h1);
    wait_irq(0);
    chk(beats, 1);
    chk(xq, 8'h04);
    rd(8'h00, 32'h407);
    apb(1'b1, 8'h00, 32'h406);
    rd(8'h00, 32'h406);
    apb(1'b1, 8'h00, 32'h404);
    chk(done_interrupt, 4'h0);
    apb(1'b1, 8'h00, 32'h6);
    rd(8'h00, 32'h4);
    $display("Test auto done");
    b0 = beats;
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h00, 32'h43d);
    wait_irq(0);
    chk(beats - b0, 8);
    chk(xq, 8'h15);
    rd(8'h00, 32'h43f);
    apb(1'b1, 8'h00, 32'h0);
    $display("Test sixteen done");
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h04, 32'h5);
    b0 = beats;
    repeat (10) @(posedge sys_clk);
    chk(beats - b0, 0);
    ext_request_pin_n[1] <= 1'b0;
    wait_irq(1);
    chk(ack_seen, 1'b1);
    chk(xq, 8'h44);
    ext_request_pin_n[1] <= 1'b1;
    rd(8'h04, 32'h7);
    apb(1'b1, 8'h04, 32'h0);
    ext_request_pin_n[1] <= 1'b0;
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h04, 32'h245);
    b0 = beats;
    repeat (10) @(posedge sys_clk);
    chk(beats - b0, 0);
    ext_request_pin_n[1] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ext_request_pin_n[1] <= 1'b0;
    wait_irq(1);
    chk(xq, 8'h46);
    ext_request_pin_n[1] <= 1'b1;
    rd(8'h04, 32'h247);
    apb(1'b1, 8'h04, 32'h0);
    ext_request_pin_n[0] <= 1'b0;
    apb(1'b1, 8'h00, 32'h101);
    b0 = beats;
    repeat (20) @(posedge sys_clk);
    chk(beats - b0, 0);
    ext_request_pin_n[0] <= 1'b1;
    apb(1'b1, 8'h00, 32'h0);
    $display("Test external done");
    delay <= 4'h8;
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h00, 32'h401);
    nmi_event <= 1'b1;
    ae_event <= 1'b1;
    @(posedge sys_clk);
    nmi_event <= 1'b0;
    ae_event <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(xfer_valid, 1'b0);
    rd(8'h00, 32'h401);
    rd(8'h24, 32'h7);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h24, 32'h1);
    rd(8'h24, 32'h1);
    $display("Test abort done");
    periph_n <= 6'h3e;
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h00, 32'ha05);
    b0 = beats;
    repeat (10) @(posedge sys_clk);
    chk(beats - b0, 0);
    periph_n <= 6'h3f;
    @(posedge sys_clk);
    periph_n <= 6'h3e;
    wait_irq(0);
    periph_n <= 6'h3f;
    rd(8'h00, 32'ha07);
    apb(1'b1, 8'h00, 32'h0);
    $display("Test peripheral done");
    apb(1'b1, 8'h20, 32'h100);
    apb(1'b1, 8'h1c, 32'h1);
    b0 = beats;
    apb(1'b1, 8'h0c, 32'h101405);
    wait_irq(3);
    chk(beats - b0, 2);
    chk(xq, 8'hc4);
    rd(8'h20, 32'h104);
    chk(src_ptr, 32'h104);
    rd(8'h0c, 32'h101407);
    $display("Test indirect done");
    print_verdict();
  end
endmodule : tb
